/* File: hdl/dfr_supervisor.v */
/*
 * Drive fault-recovery supervisor: reference-loss detection with optional
 * held speed, automatic restart with attempt counter, braking resistor
 * overheat protection and five programmable contact outputs, all set
 * up over APB.
 * Assumes fault inputs are synchronous levels, the speed search and the
 * self-diagnosis are done elsewhere and answered by handshake.
 */
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "dfr_defs.vh"

module dfr_supervisor #(
    parameter [31:0] LOSS_WIN_CYC = `DFR_LOSS_WIN_CYC, // Loss window.
    parameter [39:0] CLEAR_CYC    = `DFR_CLEAR_CYC     // Counter clear time.
) (
    input  wire        clock,                 // 125 MHz system clock.
    input  wire        rst,                   // Synchronous reset, high.
    input  wire [11:0] paddr,                 // APB address.
    input  wire        psel,                  // APB select.
    input  wire        penable,               // APB enable.
    input  wire        pwrite,                // APB write.
    input  wire [31:0] pwdata,                // APB write data.
    output wire        pready,                // APB ready, always high.
    output reg  [31:0] prdata,                // APB read data.
    output wire        pslverr,               // APB error, unmapped.
    input  wire [15:0] freq_ref,              // Analog frequency reference.
    input  wire [15:0] run_freq,              // Present output frequency.
    input  wire        running,               // Drive is running.
    input  wire        overcurrent_fault,     // Fault input.
    input  wire        ground_fault,          // Fault input.
    input  wire        fuse_blown_fault,      // Fault input.
    input  wire        overvoltage_fault,     // Fault input.
    input  wire        undervoltage_fault,    // Fault input.
    input  wire        mains_voltage_fault,   // Fault input.
    input  wire        output_phase_loss_fault, // Fault input.
    input  wire        brake_res_overheat,    // Resistor overheat sensor.
    input  wire        brake_transistor_fault, // Fault input.
    input  wire        motor_overload_fault,  // Fault input.
    input  wire        drive_overload_fault,  // Fault input.
    input  wire        motor_overheat_fault,  // Fault input.
    input  wire        overtorque_fault_a,    // Fault input.
    input  wire        overtorque_fault_b,    // Fault input.
    input  wire        other_fault,           // Any non-eligible fault.
    input  wire        diag_done,             // Self-diagnosis finished.
    input  wire        diag_pass,             // Diagnosis found no error.
    input  wire        search_done,           // Speed search finished.
    input  wire        fault_reset,           // Operator fault reset pulse.
    output reg  [15:0] speed_ref,             // Speed reference to the drive.
    output reg         diag_start,            // Start self-diagnosis pulse.
    output reg         search_start,          // Start speed search pulse.
    output reg  [15:0] search_freq,           // Speed search start frequency.
    output reg         coast_stop,            // Cut output, coast to stop.
    output reg         trip_latched,          // Protection tripped.
    output reg         brake_res_overheat_alarm, // Operator display alarm.
    output reg  [4:0]  contact_out,           // Multi-function contacts.
    output wire        irq                    // Interrupt, high level.
);

    localparam [2:0] ST_RUN    = 3'd0;
    localparam [2:0] ST_DIAG   = 3'd1;
    localparam [2:0] ST_SEARCH = 3'd2;
    localparam [2:0] ST_TRIP   = 3'd3;
    localparam [2:0] ST_ACKED  = 3'd4;

    reg  [31:0] ctrl;
    reg  [39:0] outsel;
    reg  [4:0]  irq_stat;
    reg  [4:0]  irq_mask;
    reg  [2:0]  state;
    reg  [3:0]  attempts;
    reg  [39:0] clear_cnt;
    reg         restarted;
    reg  [31:0] win_cnt;
    reg  [15:0] win_start;
    reg         ref_lost;
    reg  [15:0] held_speed;
    reg  [15:0] pre_loss;
    reg  [4:0]  ev;
    reg  [2:0]  next_state;

    wire loss_sel     = ctrl[`DFR_CTRL_LOSS_SEL];
    wire rst_contact  = ctrl[`DFR_CTRL_RST_CONTACT];
    wire brk_en       = ctrl[`DFR_CTRL_BRK_EN];
    wire [1:0] ride   = ctrl[`DFR_CTRL_RIDE_LSB +: 2];
    wire [3:0] limit  = ctrl[`DFR_CTRL_LIMIT_LSB +: 4];

    wire apb_wr = psel & penable & pwrite;
    wire mapped = (paddr == `DFR_REG_CTRL) | (paddr == `DFR_REG_OUTSEL) |
                  (paddr == `DFR_REG_STATUS) | (paddr == `DFR_REG_IRQ_STAT) |
                  (paddr == `DFR_REG_IRQ_MASK) | (paddr == `DFR_REG_HOLD);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign irq     = |(irq_stat & irq_mask);

    // Overheat only counts as a fault while protection is enabled.
    wire brk_heat  = brake_res_overheat & brk_en;
    wire uv_ok     = undervoltage_fault &
                     ((ride == 2'd1) | (ride == 2'd2));
    wire elig      = overcurrent_fault | ground_fault | fuse_blown_fault |
                     overvoltage_fault | uv_ok | mains_voltage_fault |
                     output_phase_loss_fault | brk_heat |
                     brake_transistor_fault | motor_overload_fault |
                     drive_overload_fault | motor_overheat_fault |
                     overtorque_fault_a | overtorque_fault_b;
    wire inelig    = other_fault |
                     (undervoltage_fault & ~uv_ok);
    wire any_fault = elig | inelig;

    // A window compare with 32-bit products avoids a divider.
    wire [31:0] drop_x100 = ({16'h0000, win_start} -
                             {16'h0000, freq_ref}) * 32'd100;
    wire [31:0] start_x90 = {16'h0000, win_start} * `DFR_LOSS_PCT;
    wire loss_hit = (freq_ref < win_start) && (win_start != 16'h0000) &&
                    (drop_x100 >= start_x90);
    wire [31:0] hold_x80 = {16'h0000, pre_loss} * `DFR_HOLD_PCT;
    // Eighty percent of a 16-bit value always fits back in 16 bits.
    wire [31:0] hold_val = hold_x80 / 32'd100;

    always @(posedge clock) begin
        if (rst) begin
            win_cnt    <= 32'h0000_0000;
            win_start  <= 16'h0000;
            ref_lost   <= 1'b0;
            held_speed <= 16'h0000;
            pre_loss   <= 16'h0000;
        end else begin
            if (win_cnt >= LOSS_WIN_CYC - 32'd1) begin
                win_cnt   <= 32'h0000_0000;
                win_start <= freq_ref;
                if (!ref_lost)
                    pre_loss <= win_start;
            end else begin
                win_cnt <= win_cnt + 32'd1;
            end
            // Loss stands until the reference comes back to the hold or above.
            if (loss_hit && !ref_lost) begin
                ref_lost   <= 1'b1;
                held_speed <= hold_val[15:0];
            end else if (ref_lost && freq_ref >= held_speed) begin
                ref_lost <= 1'b0;
            end
        end
    end

    always @(posedge clock) begin
        if (rst)
            speed_ref <= 16'h0000;
        else if (ref_lost && loss_sel)
            speed_ref <= held_speed;
        else
            speed_ref <= freq_ref;
    end

    always @* begin
        next_state = state;
        case (state)
            ST_RUN:
                if (inelig || (elig && !running))
                    next_state = ST_TRIP;
                else if (elig && attempts >= limit)
                    next_state = ST_TRIP;
                else if (elig)
                    next_state = ST_DIAG;
            ST_DIAG:
                if (diag_done)
                    next_state = diag_pass ? ST_SEARCH : ST_TRIP;
            ST_SEARCH:
                if (search_done)
                    next_state = ST_RUN;
            ST_TRIP:
                if (!any_fault)
                    next_state = ST_ACKED;
            ST_ACKED:
                if (any_fault)
                    next_state = ST_TRIP;
                else if (fault_reset)
                    next_state = ST_RUN;
            default:
                next_state = ST_TRIP;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            state        <= ST_RUN;
            attempts     <= 4'h0;
            clear_cnt    <= 40'h00_0000_0000;
            restarted    <= 1'b0;
            diag_start   <= 1'b0;
            search_start <= 1'b0;
            search_freq  <= 16'h0000;
        end else begin
            state        <= next_state;
            diag_start   <= (state == ST_RUN) && (next_state == ST_DIAG);
            search_start <= 1'b0;
            if (state == ST_RUN && next_state == ST_DIAG)
                search_freq <= run_freq;
            if (state == ST_DIAG && next_state == ST_SEARCH) begin
                search_start <= 1'b1;
                attempts     <= attempts + 4'h1;
                restarted    <= 1'b1;
                clear_cnt    <= 40'h00_0000_0000;
            end else if (state == ST_ACKED && next_state == ST_RUN) begin
                attempts  <= 4'h0;
                restarted <= 1'b0;
            end else if (state == ST_RUN && restarted && running &&
                         !any_fault) begin
                if (clear_cnt >= CLEAR_CYC - 40'd1) begin
                    attempts  <= 4'h0;
                    restarted <= 1'b0;
                    clear_cnt <= 40'h00_0000_0000;
                end else begin
                    clear_cnt <= clear_cnt + 40'd1;
                end
            end else if (any_fault) begin
                clear_cnt <= 40'h00_0000_0000;
            end
        end
    end

    wire restarting = (state == ST_DIAG) || (state == ST_SEARCH);
    wire tripped    = (state == ST_TRIP) || (state == ST_ACKED);
    wire fault_con  = tripped || (restarting && rst_contact);
    wire brk_cond   = brk_heat | brake_transistor_fault;

    always @(posedge clock) begin
        if (rst) begin
            coast_stop               <= 1'b0;
            trip_latched             <= 1'b0;
            brake_res_overheat_alarm <= 1'b0;
        end else begin
            coast_stop   <= tripped | restarting | brk_heat;
            trip_latched <= tripped;
            brake_res_overheat_alarm <= brk_heat;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_contact
            wire [7:0] fn = outsel[gi*8 +: 8];
            always @(posedge clock) begin
                if (rst)
                    contact_out[gi] <= 1'b0;
                else
                    case (fn)
                        `DFR_FN_REF_LOSS: contact_out[gi] <= ref_lost;
                        `DFR_FN_RESTART:  contact_out[gi] <= restarting;
                        `DFR_FN_BRAKE:    contact_out[gi] <= brk_cond;
                        `DFR_FN_FAULT:    contact_out[gi] <= fault_con;
                        default:          contact_out[gi] <= 1'b0;
                    endcase
            end
        end
    endgenerate

    always @* begin
        ev = 5'b00000;
        ev[`DFR_EV_LOSS]    = loss_hit & ~ref_lost;
        ev[`DFR_EV_RESTART] = (state == ST_DIAG) && (next_state == ST_SEARCH);
        ev[`DFR_EV_TRIP]    = (state != ST_TRIP) && (next_state == ST_TRIP);
        ev[`DFR_EV_BRAKE]   = brk_cond & ~brake_res_overheat_alarm;
        ev[`DFR_EV_CLEAR]   = restarted && (state == ST_RUN) &&
                              (clear_cnt >= CLEAR_CYC - 40'd1);
    end

    // Register writes; a new event wins over a write-one clear.
    always @(posedge clock) begin
        if (rst) begin
            ctrl     <= `DFR_CTRL_RESET;
            outsel   <= 40'h00_0000_0000;
            irq_stat <= 5'b00000;
            irq_mask <= 5'b00000;
        end else begin
            irq_stat <= ev | (irq_stat &
                        ~((apb_wr && paddr == `DFR_REG_IRQ_STAT) ?
                          pwdata[4:0] : 5'b00000));
            if (apb_wr && paddr == `DFR_REG_IRQ_MASK)
                irq_mask <= pwdata[4:0];
            if (apb_wr && paddr == `DFR_REG_CTRL) begin
                ctrl <= {20'h0_0000, pwdata[11:8] > `DFR_LIMIT_MAX ?
                         `DFR_LIMIT_MAX : pwdata[11:8],
                         2'b00, pwdata[5:4], 1'b0, pwdata[2:0]};
            end
            if (apb_wr && paddr == `DFR_REG_OUTSEL)
                outsel[31:0] <= pwdata;
            if (apb_wr && paddr == `DFR_REG_HOLD)
                outsel[39:32] <= pwdata[7:0];
        end
    end

    always @(posedge clock) begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            case (paddr)
                `DFR_REG_CTRL:     prdata <= ctrl;
                `DFR_REG_OUTSEL:   prdata <= outsel[31:0];
                `DFR_REG_STATUS:   prdata <= {16'h0000, attempts, 1'b0,
                                    state, 3'b000, ref_lost, restarting,
                                    tripped, brk_cond, 1'b0};
                `DFR_REG_IRQ_STAT: prdata <= {27'h000_0000, irq_stat};
                `DFR_REG_IRQ_MASK: prdata <= {27'h000_0000, irq_mask};
                `DFR_REG_HOLD:     prdata <= {16'h0000, 8'h00,
                                              outsel[39:32]};
                default:           prdata <= 32'h0000_0000;
            endcase
    end

endmodule

/* File: hdl/dfr_defs.vh */
/*
 * Constants for the drive fault-recovery supervisor: APB register offsets,
 * field positions, reset values, function codes and timing counts.
 * Assumes a 125 MHz system clock and inclusion by bare name.
 */
`ifndef DFR_DEFS_VH
`define DFR_DEFS_VH

`define DFR_CLK_HZ            125000000
// Reference-loss window, milliseconds, and its cycle count (rounded down).
`define DFR_LOSS_WIN_MS       400
`define DFR_LOSS_WIN_CYC      ((`DFR_CLK_HZ / 1000) * `DFR_LOSS_WIN_MS)
// Fault-free run time that clears the attempt counter, minutes.
`define DFR_CLEAR_MIN         10
`define DFR_CLEAR_CYC         (40'd60 * `DFR_CLK_HZ * `DFR_CLEAR_MIN)
// Loss threshold: the drop is at least 90 percent of the window's start.
`define DFR_LOSS_PCT          90
`define DFR_HOLD_PCT          80

// Register byte offsets.
`define DFR_REG_CTRL          12'h000
`define DFR_REG_OUTSEL        12'h004
`define DFR_REG_STATUS        12'h008
`define DFR_REG_IRQ_STAT      12'h00C
`define DFR_REG_IRQ_MASK      12'h010
`define DFR_REG_HOLD          12'h014

// Control register fields.
`define DFR_CTRL_LOSS_SEL     0
`define DFR_CTRL_RST_CONTACT  1
`define DFR_CTRL_BRK_EN       2
`define DFR_CTRL_RIDE_LSB     4
`define DFR_CTRL_LIMIT_LSB    8
`define DFR_CTRL_RESET        32'h0000_0000
`define DFR_LIMIT_MAX         4'hA

// Contact output function codes.
`define DFR_FN_REF_LOSS       8'h0C
`define DFR_FN_BRAKE          8'h0D
`define DFR_FN_RESTART        8'h1E
`define DFR_FN_FAULT          8'h0E

// Interrupt event bits.
`define DFR_EV_LOSS           0
`define DFR_EV_RESTART        1
`define DFR_EV_TRIP           2
`define DFR_EV_BRAKE          3
`define DFR_EV_CLEAR          4
`define DFR_EV_W              5

`endif

/* File: testbench/dfr_supervisor_props.sv */
/* Port checker for the fault-recovery supervisor.
   Assumes one clock and a synchronous active-high reset; bound below. */
`timescale 1ns/1ps
module dfr_supervisor_props (
    input wire        clock,                   // System clock.
    input wire        rst,                     // Synchronous reset.
    input wire        psel,                    // APB select.
    input wire        penable,                 // APB enable.
    input wire        pready,                  // APB ready.
    input wire        pslverr,                 // APB error.
    input wire [15:0] run_freq,                // Running frequency.
    input wire        diag_done,               // Diagnosis finished.
    input wire        diag_pass,               // Diagnosis verdict.
    input wire        fault_reset,             // Operator fault reset.
    input wire        brake_res_overheat,      // Resistor sensor.
    input wire        diag_start,              // Diagnosis request.
    input wire        search_start,            // Search request.
    input wire [15:0] search_freq,             // Search start frequency.
    input wire        coast_stop,              // Coast command.
    input wire        trip_latched,            // Protection tripped.
    input wire        brake_res_overheat_alarm // Display alarm.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_DIAG_PULSE: assert property (diag_start |=> !diag_start)
        else $error("diag_start held longer than one cycle");
    AST_SEARCH_PASS: assert property ($rose(search_start) |->
        $past(diag_done && diag_pass))
        else $error("search started without a passed diagnosis");
    AST_SEARCH_FREQ: assert property (diag_start |->
        search_freq == $past(run_freq))
        else $error("search frequency is not the running frequency");
    AST_TRIP_NO_RESTART: assert property (trip_latched &&
        $past(trip_latched) |-> !diag_start && !search_start)
        else $error("restart activity while tripped");
    AST_BRAKE_COAST: assert property ($rose(brake_res_overheat_alarm)
        |-> ##[0:2] coast_stop)
        else $error("overheat alarm without coasting");
    AST_ALARM_CAUSE: assert property ($rose(brake_res_overheat_alarm)
        |-> $past(brake_res_overheat) || $past(brake_res_overheat, 2))
        else $error("overheat alarm without sensor");
    AST_SLVERR_ACCESS: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside an access phase");
    AST_PREADY: assert property (pready)
        else $error("pready low");
    AST_TRIP_RELEASE: assert property ($fell(trip_latched) |->
        $past(fault_reset) || $past(fault_reset, 2))
        else $error("trip cleared without fault reset");

    cover property (search_start);
    cover property ($fell(trip_latched));
    cover property ($rose(brake_res_overheat_alarm));
endmodule

bind dfr_supervisor dfr_supervisor_props i_dfr_supervisor_props (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .run_freq(run_freq),
    .diag_done(diag_done), .diag_pass(diag_pass),
    .fault_reset(fault_reset), .brake_res_overheat(brake_res_overheat),
    .diag_start(diag_start), .search_start(search_start),
    .search_freq(search_freq), .coast_stop(coast_stop),
    .trip_latched(trip_latched),
    .brake_res_overheat_alarm(brake_res_overheat_alarm));

/* File: testbench/dfr_far_model.sv */
/* Far-side model: answers diagnosis and speed search requests after a
   delay and latches every contact seen closed.
   Assumes the supervisor's clock and synchronous reset. */
`timescale 1ns/1ps
module dfr_far_model #(
    parameter [3:0] DLY = 4'h3         // Answer delay, cycles.
) (
    input  wire       clock,           // System clock.
    input  wire       rst,             // Synchronous reset.
    input  wire       clr,             // Clears seen_on.
    input  wire       pass_sel,        // Verdict to give.
    input  wire       diag_start,      // Diagnosis request.
    input  wire       search_start,    // Search request.
    input  wire [4:0] contact_out,     // Contacts.
    output reg        diag_done,       // Diagnosis finished.
    output reg        diag_pass,       // Verdict.
    output reg        search_done,     // Search finished.
    output reg  [4:0] seen_on          // Contacts seen closed.
);
    reg [3:0] dcnt;
    reg [3:0] scnt;
    // The verdict toggles when not qualified, so a stale read shows up.
    always @(posedge clock) begin
        if (rst) begin
            dcnt        <= 4'h0;
            scnt        <= 4'h0;
            diag_done   <= 1'b0;
            diag_pass   <= 1'b0;
            search_done <= 1'b0;
        end else begin
            dcnt        <= diag_start ? DLY : dcnt - (dcnt != 4'h0);
            scnt        <= search_start ? DLY : scnt - (scnt != 4'h0);
            diag_done   <= (dcnt == 4'h1);
            diag_pass   <= (dcnt == 4'h1) ? pass_sel : ~diag_pass;
            search_done <= (scnt == 4'h1);
        end
        seen_on <= (rst | clr) ? 5'h00 : seen_on | contact_out;
    end
endmodule

/* File: testbench/dfr_supervisor_tb_top.sv */
/* Bench for the fault-recovery supervisor: APB set-up, reference loss,
   restarts, trips and resistor protection.
   Assumes the far-side model answers diagnosis and search. */
`timescale 1ns/1ps
`include "dfr_defs.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
    failures++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module dfr_supervisor_tb_top;
    logic        clock, rst, psel, penable, pwrite, err, running;
    logic        brake_res_overheat, fault_reset, clr, pass_sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdat;
    logic [15:0] freq_ref, run_freq;
    logic [13:0] flt;
    wire         pready, pslverr, diag_start, search_start, coast_stop;
    wire         trip_latched, brake_res_overheat_alarm, irq;
    wire         diag_done, diag_pass, search_done;
    wire  [31:0] prdata;
    wire  [15:0] speed_ref, search_freq;
    wire  [4:0]  contact_out, seen_on;
    wire         overcurrent_fault, ground_fault, fuse_blown_fault;
    wire         overvoltage_fault, undervoltage_fault, mains_voltage_fault;
    wire         output_phase_loss_fault, brake_transistor_fault;
    wire         motor_overload_fault, drive_overload_fault;
    wire         motor_overheat_fault, overtorque_fault_a;
    wire         overtorque_fault_b, other_fault;
    int          failures = 0, num_checks = 0, cyc = 0;

    assign {other_fault, overtorque_fault_b, overtorque_fault_a,
            motor_overheat_fault, drive_overload_fault,
            motor_overload_fault, brake_transistor_fault,
            output_phase_loss_fault, mains_voltage_fault,
            undervoltage_fault, overvoltage_fault, fuse_blown_fault,
            ground_fault, overcurrent_fault} = flt;

    dfr_supervisor #(.LOSS_WIN_CYC(32'h0000_0064),
        .CLEAR_CYC(40'h00_0000_00C8)) i_dfr_supervisor (.*);
    dfr_far_model i_dfr_far_model (.clock(clock), .rst(rst), .clr(clr),
        .pass_sel(pass_sel), .diag_start(diag_start),
        .search_start(search_start), .contact_out(contact_out),
        .diag_done(diag_done), .diag_pass(diag_pass),
        .search_done(search_done), .seen_on(seen_on));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            wrap_up;
        end
    end

    task wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rd_attempts;
        apb(1'b0, `DFR_REG_STATUS, 32'h0000_0000);
    endtask
    task automatic ref_step(input logic [15:0] v);
        freq_ref <= v;
        repeat (250) @(posedge clock);
        #1;
    endtask
    // Clearing seen_on with the fault keeps each restart's record apart.
    task automatic fault_pulse(input logic [13:0] f);
        clr <= 1'b1;
        flt <= f;
        @(posedge clock);
        clr <= 1'b0;
        flt <= 14'h0000;
    endtask
    task automatic wait_for(input logic trip);
        int n;
        n = 0;
        while ((trip ? trip_latched : search_start) !== 1'b1
               && n < 500) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task automatic reset_fault;
        fault_reset <= 1'b1;
        @(posedge clock);
        fault_reset <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task t_reset;
        apb(1'b0, `DFR_REG_CTRL, 32'h0000_0000);
        `CHK("ctrl", `DFR_CTRL_RESET, rdat)
        rd_attempts;
        `CHK("attempts", 4'h0, rdat[15:12])
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rdat)
        $display("test reset done");
    endtask

    task t_loss;
        apb(1'b1, `DFR_REG_OUTSEL, 32'h0D0E_1E0C);
        ref_step(16'h0065);
        `CHK("no loss", 1'b0, contact_out[0])
        ref_step(16'h03E8);
        ref_step(16'h0064);
        `CHK("loss contact", 1'b1, contact_out[0])
        `CHK("follow", 16'h0064, speed_ref)
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, `DFR_REG_IRQ_MASK, 32'h0000_0001);
        `CHK("irq", 1'b1, irq)
        ref_step(16'h03E8);
        `CHK("loss gone", 1'b0, contact_out[0])
        apb(1'b1, `DFR_REG_IRQ_STAT, 32'h0000_0001);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b1, `DFR_REG_CTRL, 32'h0000_0001);
        ref_step(16'h0064);
        `CHK("held speed", 16'h0320, speed_ref)
        ref_step(16'h03E8);
        $display("test loss done");
    endtask

    task t_eligible;
        int i;
        apb(1'b1, `DFR_REG_CTRL, 32'h0000_0110);
        for (i = 0; i < 13; i++) begin
            run_freq <= 16'h0100 + i[15:0];
            fault_pulse(14'h0001 << i);
            wait_for(1'b0);
            `CHK("search freq", 16'h0100 + i[15:0], search_freq)
            rd_attempts;
            `CHK("attempts", 4'h1, rdat[15:12])
            `CHK("restart contact", 1'b1, seen_on[1])
            `CHK("fault contact", 1'b0, seen_on[2])
            if (i == 7) `CHK("brake contact", 1'b1, seen_on[3])
            repeat (260) @(posedge clock);
            rd_attempts;
            `CHK("cleared", 4'h0, rdat[15:12])
        end
        $display("test eligible done");
    endtask

    task t_refuse;
        int k;
        for (k = 0; k < 4; k++) begin
            apb(1'b1, `DFR_REG_CTRL, k == 0 ? 32'h0000_0100 :
                k == 3 ? 32'h0000_0000 : 32'h0000_0110);
            pass_sel <= (k != 2);
            fault_pulse(k == 0 ? 14'h0010 : k == 1 ? 14'h2000 : 14'h0001);
            wait_for(1'b1);
            `CHK("trip", 1'b1, trip_latched)
            rd_attempts;
            `CHK("attempts", 4'h0, rdat[15:12])
            reset_fault;
            `CHK("trip reset", 1'b0, trip_latched)
        end
        pass_sel <= 1'b1;
        $display("test refuse done");
    endtask

    task t_limit;
        apb(1'b1, `DFR_REG_CTRL, 32'h0000_0112);
        fault_pulse(14'h0001);
        wait_for(1'b0);
        repeat (10) @(posedge clock);
        `CHK("fault contact", 1'b1, seen_on[2])
        fault_pulse(14'h0001);
        wait_for(1'b1);
        `CHK("limit trip", 1'b1, trip_latched)
        rd_attempts;
        `CHK("attempts", 4'h1, rdat[15:12])
        reset_fault;
        rd_attempts;
        `CHK("attempts reset", 4'h0, rdat[15:12])
        $display("test limit done");
    endtask

    task t_brake;
        apb(1'b1, `DFR_REG_CTRL, 32'h0000_0000);
        apb(1'b1, `DFR_REG_IRQ_STAT, 32'h0000_0008);
        apb(1'b1, `DFR_REG_IRQ_MASK, 32'h0000_0008);
        brake_res_overheat <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        `CHK("alarm off", 1'b0, brake_res_overheat_alarm)
        apb(1'b1, `DFR_REG_CTRL, 32'h0000_0004);
        apb(1'b1, `DFR_REG_HOLD, 32'h0000_000D);
        repeat (5) @(posedge clock);
        #1;
        `CHK("alarm", 1'b1, brake_res_overheat_alarm)
        `CHK("coast", 1'b1, coast_stop)
        `CHK("brake contact", 1'b1, contact_out[3])
        `CHK("contact 4", 1'b1, contact_out[4])
        `CHK("irq", 1'b1, irq)
        brake_res_overheat <= 1'b0;
        apb(1'b1, `DFR_REG_IRQ_STAT, 32'h0000_0008);
        `CHK("irq cleared", 1'b0, irq)
        $display("test brake done");
    endtask

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, clr, fault_reset, brake_res_overheat} = '0;
        {paddr, pwdata, flt} = '0;
        {running, pass_sel} = 2'b11;
        freq_ref = 16'h03E8;
        run_freq = 16'h0100;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_loss;
        t_eligible;
        t_refuse;
        t_limit;
        t_brake;
        wrap_up;
    end
endmodule
